// [rx_port_response_check_embed_tag.sv]
// echo check flag, encoder crc capability and raw-mode line tagging per receive port
// Behaviour
// - set response flag when echoed data mismatches while enhanced checking is enabled
// - reading status register clears response flag
// - flag reports only with enhanced checking enabled
// - capability bit 4 enables encoder crc flag
// - paged registers kept per port, routed by select
// - line count zero forwards all packets untagged
// - counts 1..3 tag first N long packets
// - tagging only in raw receiver mode
// - tagged packets carry programmed six-bit type
// - type value resets to 0x12
// - offsets 0x48, 0x49 read zero, no effect
// - enhanced check enable at 0x46, resets one
// - one read port, broadcast writes to enabled ports
`timescale 1ns/100ps
`default_nettype none
`include "rx_port_defs.svh"
module rx_port_response_check_embed_tag #(
  parameter int PORTS = 4
) (
  input  wire logic                  mclk,          // device clock, 250 MHz
  input  wire logic                  rst_n,         // async reset, active low
  input  wire logic [7:0]            reg_addr,      // register offset
  input  wire rx_port_pkg::byte_t    reg_wdata,     // write data
  input  wire logic                  reg_wr,        // write strobe, one cycle
  input  wire logic                  reg_rd,        // read strobe, one cycle
  output rx_port_pkg::byte_t         reg_rdata,     // read data, registered
  output logic                       reg_rvalid,    // read data valid pulse
  input  wire logic [1:0]            rd_port_sel,   // port picked for reads
  input  wire logic [PORTS-1:0]      wr_port_en,    // ports enabled for writes
  input  wire logic                  echo_valid,    // echoed item arrives
  input  wire logic [1:0]            echo_port,     // port the echo came on
  input  wire rx_port_pkg::byte_t    echo_expected, // item that was sent
  input  wire rx_port_pkg::byte_t    echo_returned, // item echoed back
  output logic                       enh_enable,    // enhanced checking enable
  output logic [PORTS-1:0]           resp_err_flag, // sticky response error flags
  output logic [PORTS-1:0]           crc_flag_en,   // encoder crc flag enable
  input  wire logic [PORTS-1:0]      raw_mode,      // receiver in raw mode
  input  wire logic [PORTS-1:0]      frame_start,   // frame start pulse
  input  wire logic [PORTS-1:0]      long_start,    // long packet header pulse
  input  wire logic [PORTS*6-1:0]    dtype_in,      // configured raw video type
  output logic [PORTS*6-1:0]         dtype_out,     // data type sent, registered
  output logic [PORTS-1:0]           dtype_valid    // dtype_out valid pulse
);
  // the two-bit port numbers can only reach four ports, so refuse any other count
  if (PORTS != 4) begin : g_ports_check
    $error("port select serves exactly four ports");
  end

  // address decode
  wire hit_ctl    = (reg_addr == `ADDR_ERR_CTL);
  wire hit_status = (reg_addr == `ADDR_RESP_STATUS);
  wire hit_cap    = (reg_addr == `ADDR_LINK_CAP);
  wire hit_tag    = (reg_addr == `ADDR_LINE_TAG);
  // broadcast write strobes into the per-port bank
  wire [PORTS-1:0] wr_cap = {PORTS{reg_wr & hit_cap}} & wr_port_en;
  wire [PORTS-1:0] wr_tag = {PORTS{reg_wr & hit_tag}} & wr_port_en;

  logic [PORTS*2-1:0] line_count;  // tagged line count per port
  logic [PORTS*6-1:0] type_value;  // tagged type per port

  // paged storage lives in its own bank
  tag_reg_bank #(.PORTS(PORTS)) u_bank (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .wr_cap     (wr_cap),
    .wr_tag     (wr_tag),
    .wdata      (reg_wdata),
    .crc_en     (crc_flag_en),
    .line_count (line_count),
    .type_value (type_value)
  );

  // enhanced check enable, global not paged
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      enh_enable <= `RST_ENH_ENABLE;
    end else if (reg_wr && hit_ctl) begin
      enh_enable <= reg_wdata[`BIT_ENH_ENABLE];
    end
  end

  // echo check: compare what went out with what came back
  wire echo_bad = echo_valid & (echo_expected != echo_returned) & enh_enable;
  wire status_read = reg_rd & hit_status;

  // sticky flags; a set in the clearing cycle wins so no error is lost
  for (genvar p = 0; p < PORTS; p++) begin : g_flag
    wire set_p = echo_bad & (echo_port == 2'(p));
    wire clr_p = status_read & (rd_port_sel == 2'(p));
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        resp_err_flag[p] <= 1'b0;
      end else if (set_p) begin
        resp_err_flag[p] <= 1'b1;
      end else if (clr_p) begin
        resp_err_flag[p] <= 1'b0;
      end
    end
  end

  // read mux, picked port only; spare and unmapped offsets read zero
  wire                       sel_flag = resp_err_flag[rd_port_sel] & enh_enable;
  wire rx_port_pkg::byte_t   rd_ctl   = `RST_BYTE | (8'h01 << `BIT_ENH_ENABLE) & {8{enh_enable}};
  wire rx_port_pkg::byte_t   rd_stat  = {7'h00, sel_flag};
  wire rx_port_pkg::byte_t   rd_cap   = {3'h0, crc_flag_en[rd_port_sel], 4'h0};
  wire rx_port_pkg::byte_t   rd_tag   = {line_count[rd_port_sel*2 +: 2],
                                         type_value[rd_port_sel*6 +: 6]};
  wire rx_port_pkg::byte_t   rd_mux   = hit_ctl    ? rd_ctl  :
                                        hit_status ? rd_stat :
                                        hit_cap    ? rd_cap  :
                                        hit_tag    ? rd_tag  : `RST_BYTE;

  // read answer one cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= `RST_BYTE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // per-port long packet counter and type substitution
  for (genvar p = 0; p < PORTS; p++) begin : g_tag
    rx_port_pkg::lines_t pkt_count;   // long packets seen this frame
    wire rx_port_pkg::lines_t lines  = line_count[p*2 +: 2];
    wire rx_port_pkg::lines_t cur    = frame_start[p] ? `LINES_NONE : pkt_count;
    // a count of zero never tags, since cur < 0 is false
    wire do_tag = raw_mode[p] & (lines != `LINES_NONE) & (cur < lines);
    wire rx_port_pkg::lines_t next_count = (cur == `LINES_MAX) ? cur : cur + `ONE_LINE;
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        pkt_count        <= `LINES_NONE;
        dtype_out[p*6 +: 6] <= `RST_TYPE_VALUE;
        dtype_valid[p]   <= 1'b0;
      end else begin
        dtype_valid[p] <= long_start[p];
        if (long_start[p]) begin
          pkt_count <= next_count;
          dtype_out[p*6 +: 6] <= do_tag ? type_value[p*6 +: 6] : dtype_in[p*6 +: 6];
        end else if (frame_start[p]) begin
          pkt_count <= `LINES_NONE;
        end
      end
    end
  end

  // checks
  property p_resp_set;
    @(posedge mclk) disable iff (!rst_n)
      (echo_valid && echo_expected != echo_returned && enh_enable)
      |=> resp_err_flag[$past(echo_port)];
  endproperty
  a_resp_set: assert property (p_resp_set) else $error("echo mismatch did not set flag");

  property p_read_clear;
    @(posedge mclk) disable iff (!rst_n)
      (status_read && !echo_valid) |=> !resp_err_flag[$past(rd_port_sel)];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status read left flag set");

  property p_flag_gate;
    @(posedge mclk) disable iff (!rst_n)
      status_read |=> reg_rvalid && reg_rdata[`BIT_RESP_ERR] ==
        ($past(resp_err_flag[rd_port_sel]) && $past(enh_enable));
  endproperty
  a_flag_gate: assert property (p_flag_gate) else $error("status read wrong flag");

  property p_spare_zero;
    @(posedge mclk) disable iff (!rst_n)
      reg_rd && (reg_addr == `ADDR_SPARE_A || reg_addr == `ADDR_SPARE_B)
      |=> reg_rdata == `RST_BYTE;
  endproperty
  a_spare_zero: assert property (p_spare_zero) else $error("spare offset not zero");

  property p_cap_write;
    @(posedge mclk) disable iff (!rst_n)
      (reg_wr && hit_cap && wr_port_en[0]) |=> crc_flag_en[0] == $past(reg_wdata[`BIT_ENC_CRC_EN]);
  endproperty
  a_cap_write: assert property (p_cap_write) else $error("capability write lost");

  property p_no_tag;
    @(posedge mclk) disable iff (!rst_n)
      long_start[0] && (line_count[1:0] == `LINES_NONE || !raw_mode[0])
      |=> dtype_out[5:0] == $past(dtype_in[5:0]);
  endproperty
  a_no_tag: assert property (p_no_tag) else $error("untagged packet altered");

  property p_first_tag;
    @(posedge mclk) disable iff (!rst_n)
      frame_start[0] && long_start[0] && raw_mode[0] && line_count[1:0] != `LINES_NONE
      |=> dtype_out[5:0] == $past(type_value[5:0]);
  endproperty
  a_first_tag: assert property (p_first_tag) else $error("first line not tagged");

  property p_csi_mode;
    @(posedge mclk) disable iff (!rst_n)
      long_start[1] && !raw_mode[1] |=> dtype_out[11:6] == $past(dtype_in[11:6]);
  endproperty
  a_csi_mode: assert property (p_csi_mode) else $error("tagging in csi mode");

  // a line tagging write must leave port 3 untouched while its write enable is off
  property p_tag_keep;
    @(posedge mclk) disable iff (!rst_n)
      (reg_wr && hit_tag && !wr_port_en[3])
      |=> $stable(line_count[7:6]) && $stable(type_value[23:18]);
  endproperty
  a_tag_keep: assert property (p_tag_keep) else $error("disabled port was written");

  // main scenarios worth seeing at least once
  wire pkt_count_is_two = (g_tag[0].pkt_count == 2'h2); // third packet of a frame on port 0
  c_resp_err: cover property (@(posedge mclk) disable iff (!rst_n) echo_bad ##[1:20] status_read);
  c_broadcast: cover property (@(posedge mclk) disable iff (!rst_n) reg_wr && hit_tag && &wr_port_en);
  c_three_tag: cover property (@(posedge mclk) disable iff (!rst_n)
    long_start[0] && raw_mode[0] && line_count[1:0] == `LINES_MAX && pkt_count_is_two);
  c_raw_off: cover property (@(posedge mclk) disable iff (!rst_n) long_start[1] && !raw_mode[1]);
endmodule
`default_nettype wire

// [rx_port_defs.svh]
// register offsets, field positions and reset values of the receive-port register subset
`ifndef RX_PORT_DEFS_SVH
`define RX_PORT_DEFS_SVH

`define ADDR_ERR_CTL      8'h46
`define ADDR_RESP_STATUS  8'h47
`define ADDR_SPARE_A      8'h48
`define ADDR_SPARE_B      8'h49
`define ADDR_LINK_CAP     8'h4A
`define ADDR_LINE_TAG     8'h4B

`define BIT_ENH_ENABLE    5
`define BIT_RESP_ERR      0
`define BIT_ENC_CRC_EN    4
`define LSB_TYPE_VALUE    0
`define MSB_TYPE_VALUE    5
`define LSB_LINE_COUNT    6
`define MSB_LINE_COUNT    7

`define RST_ENH_ENABLE    1'h1
`define RST_TYPE_VALUE    6'h12
`define RST_LINE_COUNT    2'h0
`define RST_ENC_CRC_EN    1'h0
`define RST_BYTE          8'h00
`define LINES_NONE        2'h0
`define LINES_MAX         2'h3
`define ONE_LINE          2'h1

`endif

// [rx_port_pkg.sv]
// shared types of the receive-port register subset
package rx_port_pkg;
  typedef logic [5:0] dtype_t;   // packet data type field
  typedef logic [1:0] lines_t;   // tagged line count / long packet count
  typedef logic [7:0] byte_t;    // register byte
endpackage

// [tag_reg_bank.sv]
// per-port storage of the capability bit and the line tagging byte
`timescale 1ns/100ps
`default_nettype none
`include "rx_port_defs.svh"
module tag_reg_bank #(
  parameter int PORTS = 4
) (
  input  wire logic                  mclk,       // device clock
  input  wire logic                  rst_n,      // async reset, active low
  input  wire logic [PORTS-1:0]      wr_cap,     // write strobe per port, capability reg
  input  wire logic [PORTS-1:0]      wr_tag,     // write strobe per port, tagging reg
  input  wire rx_port_pkg::byte_t    wdata,      // write data
  output logic [PORTS-1:0]           crc_en,     // encoder crc flag enable per port
  output logic [PORTS*2-1:0]         line_count, // tagged line count per port
  output logic [PORTS*6-1:0]         type_value  // tagged type value per port
);
  // at least one port slice is needed
  if (PORTS < 1) begin : g_ports_check
    $error("bank needs at least one port");
  end

  // one storage slice per port; broadcast writes may hit several at once
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        crc_en[p]            <= `RST_ENC_CRC_EN;
        line_count[p*2 +: 2] <= `RST_LINE_COUNT;
        type_value[p*6 +: 6] <= `RST_TYPE_VALUE;
      end else begin
        if (wr_cap[p]) begin
          crc_en[p] <= wdata[`BIT_ENC_CRC_EN];
        end
        if (wr_tag[p]) begin
          line_count[p*2 +: 2] <= wdata[`MSB_LINE_COUNT:`LSB_LINE_COUNT];
          type_value[p*6 +: 6] <= wdata[`MSB_TYPE_VALUE:`LSB_TYPE_VALUE];
        end
      end
    end
  end
endmodule
`default_nettype wire

// [serializer_echo_model.sv]
// remote serializer model that echoes control channel items back to the hub
`timescale 1ns/100ps
`default_nettype none
module serializer_echo_model (
  input  wire logic       mclk,          // device clock
  input  wire logic       send,          // item forwarded to the serializer
  input  wire logic [1:0] tx_port,       // port the item goes out on
  input  wire logic [7:0] tx_item,       // item sent
  input  wire logic       bad,           // corrupt the echo on purpose
  output var  logic       echo_valid,    // echoed item arrives
  output var  logic [1:0] echo_port,     // port of the echo
  output var  logic [7:0] echo_expected, // item that was sent
  output var  logic [7:0] echo_returned  // item echoed back
);
  logic       pend;      // an item awaits its echo
  logic [1:0] pend_port; // its port
  logic [7:0] pend_item; // its value
  logic       pend_bad;  // echo it wrongly
  initial begin
    echo_valid = 1'b0;
    echo_port = 2'h0;
    echo_expected = 8'h00;
    echo_returned = 8'hFF;
  end
  // take the forwarded item at the device edge
  always @(posedge mclk) begin
    pend <= send;
    pend_port <= tx_port;
    pend_item <= tx_item;
    pend_bad <= bad;
  end
  // echo half a cycle later, on the falling edge; idle bytes toggle so a stale value never looks current
  always @(negedge mclk) begin
    echo_valid <= pend;
    if (pend) begin
      echo_port <= pend_port;
      echo_expected <= pend_item;
      echo_returned <= pend_bad ? ~pend_item : pend_item;
    end else begin
      echo_expected <= ~echo_expected;
      echo_returned <= ~echo_returned;
    end
  end
endmodule
`default_nettype wire

// [rx_port_response_check_embed_tag_tb.sv]
// self-checking bench for the receive-port register subset
`timescale 1ns/100ps
`default_nettype none
`include "rx_port_defs.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module rx_port_response_check_embed_tag_tb;
  logic        mclk, rst_n, reg_wr, reg_rd, reg_rvalid, enh_enable; // bus and control
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, echo_expected, echo_returned, tx_item;
  logic [1:0]  rd_port_sel, echo_port, tx_port;                   // port numbers
  logic [3:0]  wr_port_en, resp_err_flag, crc_flag_en, raw_mode; // per-port levels
  logic [3:0]  frame_start, long_start, dtype_valid;             // per-port pulses
  logic [23:0] dtype_in, dtype_out;                              // data types
  logic        echo_valid, send, bad;                            // echo traffic
  int          num_errors, check_count, cycles;                  // bookkeeping
  rx_port_response_check_embed_tag #(.PORTS(4)) i_dut (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rd_port_sel(rd_port_sel),
    .wr_port_en(wr_port_en), .echo_valid(echo_valid), .echo_port(echo_port),
    .echo_expected(echo_expected), .echo_returned(echo_returned), .enh_enable(enh_enable),
    .resp_err_flag(resp_err_flag), .crc_flag_en(crc_flag_en), .raw_mode(raw_mode),
    .frame_start(frame_start), .long_start(long_start), .dtype_in(dtype_in),
    .dtype_out(dtype_out), .dtype_valid(dtype_valid));
  serializer_echo_model i_model (.mclk(mclk), .send(send), .tx_port(tx_port),
    .tx_item(tx_item), .bad(bad), .echo_valid(echo_valid), .echo_port(echo_port),
    .echo_expected(echo_expected), .echo_returned(echo_returned));
  // free-running device clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // hang guard, the tests need about a hundred cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one-cycle write strobe to the enabled ports
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] en);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    wr_port_en = en;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  // one-cycle read strobe, answer looked at in its single valid cycle
  task automatic rdc(input logic [7:0] a, input logic [1:0] s, input logic [7:0] exp);
    @(negedge mclk);
    reg_addr = a;
    rd_port_sel = s;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, exp)
  endtask
  // forward one item and wait until its echo has been judged
  task automatic echo(input logic [1:0] p, input logic b);
    @(negedge mclk);
    send = 1'b1;
    tx_port = p;
    tx_item = 8'h5A;
    bad = b;
    @(negedge mclk);
    send = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  // one long packet on a port, optionally the first of a new frame
  task automatic pkt(input int p, input logic fs, input logic [5:0] exp);
    @(negedge mclk);
    frame_start[p] = fs;
    long_start[p] = 1'b1;
    @(negedge mclk);
    frame_start = 4'h0;
    long_start = 4'h0;
    `CHK(dtype_valid[p], 1'b1)
    `CHK(dtype_out[6*p+:6], exp)
  endtask
  initial begin
    {reg_wr, reg_rd, send, bad, rst_n} = 5'h00;
    {reg_addr, reg_wdata, tx_item, rd_port_sel, tx_port} = 28'h0;
    {wr_port_en, raw_mode, frame_start, long_start} = 16'h0000;
    dtype_in = {4{6'h2B}};
    // two full cycles in reset, released off the sampling edge
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    rdc(`ADDR_ERR_CTL, 2'h0, 8'h20);
    rdc(`ADDR_LINE_TAG, 2'h3, 8'h12);
    rdc(`ADDR_LINK_CAP, 2'h1, 8'h00);
    wr(`ADDR_SPARE_A, 8'hFF, 4'hF);
    wr(`ADDR_SPARE_B, 8'hFF, 4'hF);
    wr(8'h45, 8'hFF, 4'hF);
    rdc(`ADDR_SPARE_A, 2'h0, 8'h00);
    rdc(`ADDR_SPARE_B, 2'h0, 8'h00);
    rdc(8'h45, 2'h0, 8'h00);
    $display("test reset and reserved done");
    echo(2'h1, 1'b1);
    `CHK(resp_err_flag, 4'b0010)
    rdc(`ADDR_RESP_STATUS, 2'h1, 8'h01);
    rdc(`ADDR_RESP_STATUS, 2'h1, 8'h00);
    echo(2'h2, 1'b0);
    `CHK(resp_err_flag, 4'b0000)
    echo(2'h0, 1'b1);
    `CHK(resp_err_flag, 4'b0001)
    wr(`ADDR_ERR_CTL, 8'h00, 4'hF);
    `CHK(enh_enable, 1'b0)
    rdc(`ADDR_RESP_STATUS, 2'h0, 8'h00);
    echo(2'h3, 1'b1);
    `CHK(resp_err_flag, 4'b0000)
    rdc(`ADDR_RESP_STATUS, 2'h3, 8'h00);
    wr(`ADDR_ERR_CTL, 8'h20, 4'hF);
    `CHK(enh_enable, 1'b1)
    $display("test echo check done");
    wr(8'hBA, 8'h00, 4'hF);
    wr(`ADDR_LINK_CAP, 8'h10, 4'b0101);
    `CHK(crc_flag_en, 4'b0101)
    for (int p = 0; p < 4; p++)
      rdc(`ADDR_LINK_CAP, 2'(p), (p % 2 == 0) ? 8'h10 : 8'h00);
    $display("test port paging done");
    raw_mode = 4'hF;
    for (int c = 0; c < 4; c++) begin
      wr(`ADDR_LINE_TAG, {c[1:0], 6'h2A}, 4'b0001);
      for (int n = 0; n < 4; n++)
        pkt(0, n == 0, (n < c) ? 6'h2A : 6'h2B);
    end
    wr(`ADDR_LINE_TAG, 8'hEA, 4'hF);
    pkt(1, 1'b1, 6'h2A);
    raw_mode = 4'h0;
    pkt(0, 1'b1, 6'h2B);
    pkt(1, 1'b1, 6'h2B);
    $display("test line tagging done");
    summarize();
  end
endmodule
`default_nettype wire
